/* rtl/status_regs_pkg.sv */
/*
  Package for the status and interrupt summary register group: register
  addresses, bit positions, identity values and the packed carriers.
  Assumes nothing of its surroundings; every design file except pin_sync imports it.
*/
package status_regs_pkg;

  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_ID_UPPER = 8'h30;
  localparam logic [7:0] ADDR_ID_LOWER = 8'h31;
  localparam logic [7:0] ADDR_CFG_STATUS = 8'h40;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h41;
  localparam logic [7:0] ADDR_IRQ_SUMMARY = 8'h42;
  localparam logic [7:0] ADDR_GLOBAL_IRQ = 8'h43;
  localparam logic [7:0] STATUS_BASE = 8'h40;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CFG_CONFIGURED_BIT = 7;
  localparam int SUM_OUTPUT_CLOCK_BIT = 5;
  localparam int SUM_INPUT_CLOCK_BIT = 4;
  localparam int SUM_PLL_BIT = 2;
  localparam int SUM_GLOBAL_ENABLE_BIT = 1;
  localparam int SUM_GLOBAL_FLAG_BIT = 0;
  localparam int BOOT_DONE_BIT = 7;
  localparam int NUM_PINS = 4;

  // ************************************************************
  // Identity and reset values
  // ************************************************************
  // The identifier value is arbitrary.
  localparam logic [11:0] DEVICE_ID_DEFAULT = 12'ha5c;
  // First silicon revision reads as zero.
  localparam logic [3:0] REVISION_DEFAULT = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] data;
  } regAccess_t;

  typedef struct packed {
    logic enable;
    logic [4:0] regSel;
    logic [2:0] bitSel;
  } statusSelect_t;

endpackage

/* rtl/pin_sync.sv */
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes one system clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_pinOut;

  always_comb begin
    next_stage1 = sys_rst ? '0 : pinIn;
    next_pinOut = sys_rst ? '0 : stage1;
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk) begin
    stage1 <= next_stage1;
    pinOut <= next_pinOut;
  end

endmodule

/* rtl/status_and_irq_summary_regs.sv */
/*
  Status register group: device identity, configuration status with
  strap latches, pin-change latches, interrupt summary and boot-done.
  Assumes the register port of the device core, a boot controller that
  writes through its own port while busy, and pins that are asynchronous.
*/
// Functional notes
// RULE1 - Twelve-bit read-only identifier at 30h/31h.
// RULE2 - Revision in 31h low nibble, from zero.
// RULE3 - Configured flag: reset clears, any write sets.
// RULE4 - Host resets device before script if configured.
// RULE5 - Interface mode latched at reset pin rise.
// RULE6 - Test bit latched at reset rise, hard release.
// RULE7 - Autoconfig select latched at reset rise, hard release.
// RULE8 - Pin change latches set on either edge.
// RULE9 - Latches clear only by writing one.
// RULE10 - Latch raises request only when enabled.
// RULE11 - Real-time pin bits show raw level.
// RULE12 - Summary bits OR the three source registers.
// RULE13 - Global enable gates the source summaries.
// RULE14 - Global flag from summaries or enabled latches.
// RULE15 - Global flag reaches pin via status output.
// RULE16 - Boot-done clears on reset, sets when finished.
// RULE17 - Host cannot read registers during autoconfig.
// RULE18 - Script routes boot-done to pin zero.
// RULE19 - Host writes ignored during autoconfig.
// RULE20 - Host may poll a harmless enable bit.
// RULE21 - Pin-change enables read-write at 43h.
// RULE22 - Status output follows selected register bit.
// RULE23 - Unassigned and read-only bits ignore writes.
`timescale 1ns/1ps
module status_and_irq_summary_regs
  import status_regs_pkg::*;
#(
  parameter logic [11:0] DEVICE_ID = status_regs_pkg::DEVICE_ID_DEFAULT,
  parameter logic [3:0] REVISION = status_regs_pkg::REVISION_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_pin_n,
  input wire logic hard_reset_bit,
  input wire logic soft_reset_bit,
  input wire logic [1:0] interfaceSelectPins,
  input wire logic [status_regs_pkg::NUM_PINS-1:0] gpioPins,
  input wire status_regs_pkg::regAccess_t hostAccess,
  input wire status_regs_pkg::regAccess_t bootAccess,
  input wire logic autoConfigBusy,
  input wire logic bootFinished,
  input wire logic [7:0] output_clock_irq_status_reg,
  input wire logic [3:0] input_clock_irq_status_reg,
  input wire logic [1:0] pll_irq_status_reg,
  input wire status_regs_pkg::statusSelect_t [status_regs_pkg::NUM_PINS-1:0] pinStatusSelect,
  output logic [7:0] readData,
  output logic readValid,
  output logic globalIrqFlag,
  output logic [status_regs_pkg::NUM_PINS-1:0] pinChangeIrq,
  output logic [status_regs_pkg::NUM_PINS-1:0] statusFollow
);

  import status_regs_pkg::*;

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  // Every pin crosses two flops before any logic reads it. The reset pin is
  // treated like the others, so the device reset follows it two edges late.
  logic resetPinSync;
  logic [1:0] ifSync;
  logic [NUM_PINS-1:0] gpioSync;

  pin_sync #(.WIDTH(1)) resetSyncInst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pinIn(reset_pin_n),
    .pinOut(resetPinSync)
  );

  pin_sync #(.WIDTH(2)) ifSyncInst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pinIn(interfaceSelectPins),
    .pinOut(ifSync)
  );

  pin_sync #(.WIDTH(NUM_PINS)) gpioSyncInst (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pinIn(gpioPins),
    .pinOut(gpioSync)
  );

  // ************************************************************
  // State
  // ************************************************************
  logic resetPinPrev, next_resetPinPrev;
  logic hardPrev, next_hardPrev;
  logic [1:0] ifMode, next_ifMode;
  logic testMode, next_testMode;
  logic [2:0] autoconfig_select_latch, next_autoconfig_select_latch;
  logic configured_flag, next_configured_flag;
  logic [NUM_PINS-1:0] pinPrev, next_pinPrev;
  logic [NUM_PINS-1:0] pinChangeLatched, next_pinChangeLatched;
  // Enables share the device reset with the flags, so a soft reset leaves
  // no stale request behind.
  logic [NUM_PINS-1:0] pinChangeIrqEnable, next_pinChangeIrqEnable;
  logic global_irq_enable, next_global_irq_enable;
  logic boot_loader_done, next_boot_loader_done;
  logic [7:0] next_readData;
  logic next_readValid;
  logic next_globalIrqFlag;
  logic [NUM_PINS-1:0] next_pinChangeIrq;
  logic [NUM_PINS-1:0] next_statusFollow;

  logic deviceReset;
  logic resetRise;
  logic hardRelease;
  regAccess_t wr;
  logic writeTaken;
  logic [NUM_PINS-1:0] pinChange;
  logic [NUM_PINS-1:0] clearMask;
  logic output_clock_irq_summary;
  logic input_clock_irq_summary;
  logic pll_irq_summary;
  logic [7:0] cfgImg, pinImg, sumImg, globImg;

  // ************************************************************
  // Register images
  // ************************************************************
  // Images hold zero in every unassigned position.
  // Identity values come from parameters, so no write can reach them.
  function automatic logic [7:0] readImage(input logic [7:0] addr, input logic [7:0] cfg,
      input logic [7:0] pin, input logic [7:0] sum, input logic [7:0] glob);
    logic [7:0] value;
    value = BYTE_ZERO;
    // RULE1 identifier readback
    if (addr == ADDR_ID_UPPER) begin
      value = DEVICE_ID[11:4];
    // RULE2 revision readback
    end else if (addr == ADDR_ID_LOWER) begin
      value = {DEVICE_ID[3:0], REVISION};
    end else if (addr == ADDR_CFG_STATUS) begin
      value = cfg;
    end else if (addr == ADDR_PIN_STATUS) begin
      value = pin;
    end else if (addr == ADDR_IRQ_SUMMARY) begin
      value = sum;
    end else if (addr == ADDR_GLOBAL_IRQ) begin
      value = glob;
    end
    return value;
  endfunction

  always_comb begin
    // RULE12 source summaries
    output_clock_irq_summary = |output_clock_irq_status_reg;
    input_clock_irq_summary = |input_clock_irq_status_reg;
    pll_irq_summary = |pll_irq_status_reg;
    cfgImg = BYTE_ZERO;
    cfgImg[CFG_CONFIGURED_BIT] = configured_flag;
    cfgImg[5:4] = ifMode;
    cfgImg[3] = testMode;
    cfgImg[2:0] = autoconfig_select_latch;
    // RULE11 raw pin levels
    pinImg = {pinChangeLatched, gpioSync};
    sumImg = BYTE_ZERO;
    sumImg[SUM_OUTPUT_CLOCK_BIT] = output_clock_irq_summary;
    sumImg[SUM_INPUT_CLOCK_BIT] = input_clock_irq_summary;
    sumImg[SUM_PLL_BIT] = pll_irq_summary;
    sumImg[SUM_GLOBAL_ENABLE_BIT] = global_irq_enable;
    sumImg[SUM_GLOBAL_FLAG_BIT] = globalIrqFlag;
    globImg = BYTE_ZERO;
    globImg[BOOT_DONE_BIT] = boot_loader_done;
    globImg[NUM_PINS-1:0] = pinChangeIrqEnable;
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    deviceReset = sys_rst | ~resetPinSync | hard_reset_bit | soft_reset_bit;
    resetRise = resetPinSync & ~resetPinPrev;
    hardRelease = hardPrev & ~hard_reset_bit;
    // The boot controller has priority. A host write in the same cycle is
    // lost rather than queued, since nothing here buffers requests.
    // RULE19 host writes blocked while booting
    if (bootAccess.write) begin
      wr = bootAccess;
    end else begin
      wr = hostAccess;
      wr.write = hostAccess.write & ~autoConfigBusy;
    end
    writeTaken = wr.write;
    // The pin synchroniser leaves reset in the same cycle as the reset pin, so
    // the previous-level register still holds zero then; that is no change.
    pinChange = (gpioSync ^ pinPrev) & ~{NUM_PINS{resetRise}};
    // RULE9 write-one clears
    clearMask = (writeTaken && wr.addr == ADDR_PIN_STATUS) ? wr.data[7:4] : '0;

    next_resetPinPrev = resetPinSync;
    next_hardPrev = hard_reset_bit;
    next_pinPrev = gpioSync;
    next_ifMode = ifMode;
    next_testMode = testMode;
    next_autoconfig_select_latch = autoconfig_select_latch;
    // Straps keep their value through soft resets, and the interface mode through
    // hard resets too; only the system reset clears them, because the pins serve as
    // general inputs once the device runs.
    if (sys_rst) begin
      next_ifMode = '0;
      next_testMode = 1'b0;
      next_autoconfig_select_latch = '0;
    end else begin
      // RULE5 interface mode strap
      if (resetRise) begin
        next_ifMode = ifSync;
      end
      // RULE6 test strap
      // RULE7 autoconfig strap
      if (resetRise || hardRelease) begin
        next_testMode = gpioSync[3];
        next_autoconfig_select_latch = gpioSync[2:0];
      end
    end

    // RULE3 configured flag
    next_configured_flag = deviceReset ? 1'b0 : (configured_flag | writeTaken);
    // RULE8 change latch, set beats clear
    next_pinChangeLatched = deviceReset ? '0 : ((pinChangeLatched & ~clearMask) | pinChange);

    next_pinChangeIrqEnable = pinChangeIrqEnable;
    next_global_irq_enable = global_irq_enable;
    if (deviceReset) begin
      next_pinChangeIrqEnable = '0;
      next_global_irq_enable = 1'b0;
    // RULE23 only writable fields take data
    end else if (writeTaken && wr.addr == ADDR_IRQ_SUMMARY) begin
      next_global_irq_enable = wr.data[SUM_GLOBAL_ENABLE_BIT];
    // RULE21 pin-change enables
    end else if (writeTaken && wr.addr == ADDR_GLOBAL_IRQ) begin
      next_pinChangeIrqEnable = wr.data[NUM_PINS-1:0];
    end

    // RULE16 boot-done flag
    next_boot_loader_done = deviceReset ? 1'b0 : (boot_loader_done | bootFinished);

    // RULE10 per-pin requests
    next_pinChangeIrq = deviceReset ? '0 : (pinChangeLatched & pinChangeIrqEnable);
    // The flag is registered, so it trails its cause by one clock, the same
    // as the per-pin requests; the two stay in step for a status pin.
    // RULE13 global gate
    // RULE14 global flag
    next_globalIrqFlag = deviceReset ? 1'b0 :
      (((output_clock_irq_summary | input_clock_irq_summary | pll_irq_summary)
        & global_irq_enable) | (|(pinChangeLatched & pinChangeIrqEnable)));

    // Reads during auto-configuration get no answer at all; the host must
    // learn of completion some other way, such as a followed status pin.
    // RULE17 no host read while booting
    next_readValid = ~sys_rst & hostAccess.read & ~autoConfigBusy;
    next_readData = next_readValid ? readImage(hostAccess.addr, cfgImg, pinImg, sumImg, globImg)
      : BYTE_ZERO;

    // RULE15 global flag routed through status output
    // RULE22 status output selection
    for (int i = 0; i < NUM_PINS; i++) begin
      logic [7:0] selAddr;
      logic [7:0] selByte;
      selAddr = STATUS_BASE + {3'h0, pinStatusSelect[i].regSel};
      // Pin status bits cannot be followed, so that address reads low.
      // Addresses with nothing behind them read low too, which covers
      // selections that point past the last register of the group.
      selByte = (selAddr == ADDR_PIN_STATUS) ? BYTE_ZERO :
        readImage(selAddr, cfgImg, pinImg, sumImg, globImg);
      next_statusFollow[i] = ~sys_rst & pinStatusSelect[i].enable &
        selByte[pinStatusSelect[i].bitSel];
    end
  end

  // ************************************************************
  // Registers
  // ************************************************************
  // No register needs a reset branch of its own: every reset value is
  // chosen in the next-state logic above.
  always_ff @(posedge sys_clk) begin
    resetPinPrev <= next_resetPinPrev;
    hardPrev <= next_hardPrev;
    pinPrev <= next_pinPrev;
    ifMode <= next_ifMode;
    testMode <= next_testMode;
    autoconfig_select_latch <= next_autoconfig_select_latch;
    configured_flag <= next_configured_flag;
    pinChangeLatched <= next_pinChangeLatched;
    pinChangeIrqEnable <= next_pinChangeIrqEnable;
    global_irq_enable <= next_global_irq_enable;
    boot_loader_done <= next_boot_loader_done;
    readData <= next_readData;
    readValid <= next_readValid;
    globalIrqFlag <= next_globalIrqFlag;
    pinChangeIrq <= next_pinChangeIrq;
    statusFollow <= next_statusFollow;
  end

endmodule

/* verif/status_regs_props.sv */
/*
  Checker for the status register group: read port, interrupt and status-output relations.
  Assumes the design package and the top module's ports and parameters; bound to it at the foot of this file.
*/
`timescale 1ns/1ps
module status_regs_props
  import status_regs_pkg::*;
#(
  parameter logic [11:0] DEVICE_ID = status_regs_pkg::DEVICE_ID_DEFAULT,
  parameter logic [3:0] REVISION = status_regs_pkg::REVISION_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire status_regs_pkg::regAccess_t hostAccess,
  input wire logic autoConfigBusy,
  input wire logic [7:0] output_clock_irq_status_reg,
  input wire logic [3:0] input_clock_irq_status_reg,
  input wire logic [1:0] pll_irq_status_reg,
  input wire status_regs_pkg::statusSelect_t [status_regs_pkg::NUM_PINS-1:0] pinStatusSelect,
  input wire logic [7:0] readData,
  input wire logic readValid,
  input wire logic globalIrqFlag,
  input wire logic [status_regs_pkg::NUM_PINS-1:0] pinChangeIrq,
  input wire logic [status_regs_pkg::NUM_PINS-1:0] statusFollow
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  logic rdOk;
  assign rdOk = hostAccess.read && !autoConfigBusy;
  // ************************************************************
  // Assertions
  // ************************************************************
  a_read_answer: assert property (rdOk |=> readValid)
    else $error("read not answered");
  a_valid_cause: assert property (readValid |-> $past(rdOk))
    else $error("read answered without accepted strobe");
  a_idle_zero: assert property (!readValid |-> readData == BYTE_ZERO)
    else $error("read data not zero while idle");
  a_id_upper: assert property (rdOk && hostAccess.addr == ADDR_ID_UPPER
    |=> readData == DEVICE_ID[11:4]) else $error("upper identifier wrong");
  a_id_lower: assert property (rdOk && hostAccess.addr == ADDR_ID_LOWER
    |=> readData == {DEVICE_ID[3:0], REVISION}) else $error("lower identifier wrong");
  a_pin_irq_global: assert property (|pinChangeIrq |-> globalIrqFlag)
    else $error("enabled pin change did not raise flag");
  a_quiet_no_flag: assert property ((output_clock_irq_status_reg == 8'h00
    && input_clock_irq_status_reg == 4'h0 && pll_irq_status_reg == 2'h0)
    ##1 (pinChangeIrq == 4'h0) |-> !globalIrqFlag) else $error("flag without source");
  a_follow_pin_status: assert property (pinStatusSelect[1].regSel == 5'h01
    |=> !statusFollow[1]) else $error("pin status register followed");
  // ************************************************************
  // Covers
  // ************************************************************
  c_read: cover property (rdOk ##1 readValid);
  c_pin_irq: cover property (|pinChangeIrq);
  c_source_flag: cover property (globalIrqFlag && pinChangeIrq == 4'h0);
  c_follow: cover property (statusFollow[0]);
endmodule
bind status_and_irq_summary_regs status_regs_props #(.DEVICE_ID(DEVICE_ID),
  .REVISION(REVISION)) i_status_regs_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
  .hostAccess(hostAccess), .autoConfigBusy(autoConfigBusy),
  .output_clock_irq_status_reg(output_clock_irq_status_reg),
  .input_clock_irq_status_reg(input_clock_irq_status_reg),
  .pll_irq_status_reg(pll_irq_status_reg), .pinStatusSelect(pinStatusSelect),
  .readData(readData), .readValid(readValid), .globalIrqFlag(globalIrqFlag),
  .pinChangeIrq(pinChangeIrq), .statusFollow(statusFollow));

/* verif/status_and_irq_summary_regs_test.sv */
/*
  Self-checking bench for the status register group, driven through the
  register port. Assumes the design package and the bound checker.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module status_and_irq_summary_regs_test;
  import status_regs_pkg::*;
  // The identifier value is arbitrary.
  localparam logic [11:0] TEST_ID = 12'h3c6;
  localparam logic [3:0] TEST_REV = 4'h2;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic reset_pin_n = 1'b0;
  logic hard_reset_bit = 1'b0;
  logic soft_reset_bit = 1'b0;
  logic [1:0] ifSel = 2'b10;
  logic [3:0] gpio = 4'h5;
  regAccess_t hostAccess = '0;
  regAccess_t bootAccess = '0;
  logic autoConfigBusy = 1'b0;
  logic bootFinished = 1'b0;
  logic [7:0] ocSrc = 8'h00;
  logic [3:0] icSrc = 4'h0;
  logic [1:0] pllSrc = 2'h0;
  // Pin 0 follows boot-done, pin 1 points at the pin status register and
  // pin 2 follows the global interrupt flag.
  // boot-done on pin zero
  statusSelect_t [NUM_PINS-1:0] pinSel = {9'h000, 9'h110, 9'h108, 9'h11f};
  logic [7:0] readData;
  logic readValid;
  logic globalIrqFlag;
  logic [NUM_PINS-1:0] pinChangeIrq;
  logic [NUM_PINS-1:0] statusFollow;
  logic [7:0] sumBit [3] = '{8'h20, 8'h10, 8'h04};
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;
  status_and_irq_summary_regs #(.DEVICE_ID(TEST_ID), .REVISION(TEST_REV))
    i_status_and_irq_summary_regs (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .reset_pin_n(reset_pin_n), .hard_reset_bit(hard_reset_bit),
    .soft_reset_bit(soft_reset_bit), .interfaceSelectPins(ifSel), .gpioPins(gpio),
    .hostAccess(hostAccess), .bootAccess(bootAccess), .autoConfigBusy(autoConfigBusy),
    .bootFinished(bootFinished), .output_clock_irq_status_reg(ocSrc),
    .input_clock_irq_status_reg(icSrc), .pll_irq_status_reg(pllSrc),
    .pinStatusSelect(pinSel), .readData(readData), .readValid(readValid),
    .globalIrqFlag(globalIrqFlag), .pinChangeIrq(pinChangeIrq),
    .statusFollow(statusFollow));
  // ************************************************************
  // Clock, timeout and tasks
  // ************************************************************
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // The whole run takes about 130 cycles, so this only catches a hang.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    step(1);
    hostAccess.write = 1'b1;
    hostAccess.addr = a;
    hostAccess.data = d;
    step(1);
    hostAccess.write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic v = 1'b1);
    step(1);
    hostAccess.read = 1'b1;
    hostAccess.addr = a;
    step(1);
    hostAccess.read = 1'b0;
    `CHK(readValid, v)
    `CHK(readData, e)
  endtask
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    step(4);
    sys_rst = 1'b0;
    step(2);
    reset_pin_n = 1'b1;
    step(4);
    rd(ADDR_CFG_STATUS, 8'h25);
    rd(ADDR_PIN_STATUS, 8'h05);
    rd(ADDR_ID_UPPER, TEST_ID[11:4]);
    rd(ADDR_ID_LOWER, {TEST_ID[3:0], TEST_REV});
    rd(8'h50, 8'h00);
    wr(ADDR_ID_UPPER, 8'hff);
    rd(ADDR_ID_UPPER, TEST_ID[11:4]);
    rd(ADDR_CFG_STATUS, 8'ha5);
    wr(ADDR_GLOBAL_IRQ, 8'hff);
    rd(ADDR_GLOBAL_IRQ, 8'h0f);
    $display("identity, straps and enables done");
    gpio = 4'h4;
    step(6);
    rd(ADDR_PIN_STATUS, 8'h14);
    `CHK(pinChangeIrq, 4'h1)
    `CHK(globalIrqFlag, 1'b1)
    wr(ADDR_PIN_STATUS, 8'h00);
    rd(ADDR_PIN_STATUS, 8'h14);
    wr(ADDR_PIN_STATUS, 8'h10);
    rd(ADDR_PIN_STATUS, 8'h04);
    gpio = 4'hc;
    step(6);
    rd(ADDR_PIN_STATUS, 8'h8c);
    wr(ADDR_GLOBAL_IRQ, 8'h00);
    step(2);
    `CHK(pinChangeIrq, 4'h0)
    `CHK(globalIrqFlag, 1'b0)
    wr(ADDR_PIN_STATUS, 8'h80);
    rd(ADDR_PIN_STATUS, 8'h0c);
    $display("pin change latches done");
    for (int i = 0; i < 3; i++) begin
      ocSrc = (i == 0) ? 8'h40 : 8'h00;
      icSrc = (i == 1) ? 4'h2 : 4'h0;
      pllSrc = (i == 2) ? 2'h1 : 2'h0;
      step(2);
      rd(ADDR_IRQ_SUMMARY, sumBit[i]);
      `CHK(globalIrqFlag, 1'b0)
      `CHK(statusFollow[2], 1'b0)
      wr(ADDR_IRQ_SUMMARY, 8'hff);
      rd(ADDR_IRQ_SUMMARY, sumBit[i] | 8'h03);
      `CHK(globalIrqFlag, 1'b1)
      `CHK(statusFollow[2], 1'b1)
      wr(ADDR_IRQ_SUMMARY, 8'h00);
    end
    pllSrc = 2'h0;
    $display("interrupt summary done");
    soft_reset_bit = 1'b1;
    step(1);
    soft_reset_bit = 1'b0;
    rd(ADDR_CFG_STATUS, 8'h25);
    autoConfigBusy = 1'b1;
    wr(ADDR_GLOBAL_IRQ, 8'h08);
    rd(ADDR_GLOBAL_IRQ, 8'h00, 1'b0);
    bootAccess.write = 1'b1;
    bootAccess.addr = 8'h0d;
    bootAccess.data = 8'h1f;
    step(1);
    bootAccess.write = 1'b0;
    `CHK(statusFollow[0], 1'b0)
    bootFinished = 1'b1;
    step(1);
    bootFinished = 1'b0;
    autoConfigBusy = 1'b0;
    step(2);
    `CHK(statusFollow[0], 1'b1)
    rd(ADDR_GLOBAL_IRQ, 8'h80);
    wr(ADDR_GLOBAL_IRQ, 8'h08);
    rd(ADDR_GLOBAL_IRQ, 8'h88);
    rd(ADDR_CFG_STATUS, 8'ha5);
    $display("auto-configuration done");
    hard_reset_bit = 1'b1;
    gpio = 4'hb;
    step(4);
    hard_reset_bit = 1'b0;
    step(4);
    rd(ADDR_CFG_STATUS, 8'h2b);
    rd(ADDR_CFG_STATUS, 8'h2b);
    rd(ADDR_GLOBAL_IRQ, 8'h00);
    rd(ADDR_PIN_STATUS, 8'h0b);
    $display("hard reset done");
    final_report();
  end
endmodule
